//--- rtl/dcs_pkg.sv
// Constants and types shared by the core datapath files.
package dcs_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADR_STAT  = 8'h00;
  localparam logic [7:0] ADR_CTRL  = 8'h04;
  localparam logic [7:0] ADR_PVPG  = 8'h08;
  localparam logic [7:0] ADR_CMD   = 8'h0C;
  localparam logic [7:0] ADR_PC    = 8'h10;
  localparam logic [7:0] ADR_ACAL  = 8'h14;
  localparam logic [7:0] ADR_ACAH  = 8'h18;
  localparam logic [7:0] ADR_ACBL  = 8'h1C;
  localparam logic [7:0] ADR_ACBH  = 8'h20;
  localparam logic [7:0] ADR_LOOP  = 8'h24;
  localparam logic [7:0] ADR_MODR  = 8'h28;
  localparam logic [7:0] ADR_WBASE = 8'h40;
  // Status word bit positions.
  localparam int CW_AOVF = 15;
  localparam int CW_BOVF = 14;
  localparam int CW_ACLP = 13;
  localparam int CW_BCLP = 12;
  localparam int CW_EOVF = 11;
  localparam int CW_ECLP = 10;
  localparam int CW_LOOP = 9;
  localparam int CW_HCY  = 8;
  localparam int CW_PRIO = 5;
  localparam int CW_REP  = 4;
  localparam int CW_N    = 3;
  localparam int CW_V    = 2;
  localparam int CW_Z    = 1;
  localparam int CW_C    = 0;
  // Control word bit positions.
  localparam int CT_PRI3 = 0;
  localparam int CT_PSV  = 1;
  localparam int CT_SATA = 2;
  localparam int CT_SATB = 3;
  localparam int CT_US   = 4;
  localparam int CT_INT  = 5;
  localparam int CT_BREV = 6;
  localparam int CT_NEST = 7;
  // Command word field positions.
  localparam int CM_OP   = 0;
  localparam int CM_RD   = 4;
  localparam int CM_RS   = 8;
  localparam int CM_RT   = 12;
  localparam int CM_BYTE = 16;
  localparam int CM_ACC  = 17;
  localparam int CM_SH   = 18;
  localparam int CM_REP  = 24;
  // Divide timing and datapath constants.
  localparam int          DIV_CYCLES = 19;
  localparam logic [4:0]  DIV_LOAD   = 5'(DIV_CYCLES - 1);
  localparam logic [4:0]  DIV_ITLO   = 5'h2;
  localparam logic [4:0]  SH_MAX     = 5'h10;
  localparam logic [3:0]  W_SP       = 4'hF;
  localparam logic [3:0]  W_XP       = 4'h8;
  localparam logic [3:0]  W_YP       = 4'hA;
  localparam logic [15:0] ADDR_STEP  = 16'h0002;
  localparam logic [22:0] PC_STEP    = 23'h00_0002;
  localparam logic [39:0] SAT_POS    = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT_NEG    = 40'hFF_8000_0000;
  // Operations carried by the command word.
  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_MUL, OP_MAC, OP_SHA, OP_DIV, OP_AGU, OP_CALL
  } dcs_op_t;
  // Data memory write port.
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } dcs_dm_t;
  // Complete state of the core.
  typedef struct packed {
    logic [15:0]       csw;
    logic [7:0]        ctrl;
    logic [7:0]        pvpg;
    logic [22:0]       pc;
    logic [15:0][15:0] w;
    logic [39:0]       acca;
    logic [39:0]       accb;
    logic [31:0]       cmd;
    logic [7:0]        rcnt;
    logic              busy;
    logic              call2;
    logic [4:0]        dv_cnt;
    logic [15:0]       dq;
    logic [15:0]       dr;
    logic [15:0]       dloop;
    logic [31:0]       modr;
    logic [31:0]       prdata;
    logic              pvhit;
    logic [22:0]       pvaddr;
    dcs_dm_t           dm;
  } dcs_st_t;
  // Power-on value: every flag and control bit is clear.
  localparam dcs_st_t ST_RST = '0;
endpackage : dcs_pkg

//--- rtl/dcs_mul.sv
// Shared 17x17 multiplier with per-operand sign control.
`timescale 1ns/1ns
`default_nettype none
module dcs_mul (
  // Operands and their signedness.
  input  wire logic        [15:0] a_i,
  input  wire logic        [15:0] b_i,
  input  wire logic               a_uns_i,
  input  wire logic               b_uns_i,
  // Signed product.
  output logic signed      [33:0] p_o
);
  logic signed [16:0] a17;
  logic signed [16:0] b17;

  // One extra bit lets a single signed array serve every sign mix, so -1 x -1 stays exact.
  assign a17 = {~a_uns_i & a_i[15], a_i};
  assign b17 = {~b_uns_i & b_i[15], b_i};
  assign p_o = a17 * b17;
endmodule : dcs_mul
`default_nettype wire

//--- rtl/dcs_shift.sv
// Bidirectional 40-bit arithmetic barrel shifter.
`timescale 1ns/1ns
`default_nettype none
module dcs_shift (
  // Operand and signed shift count, positive shifts left.
  input  wire logic        [39:0] x_i,
  input  wire logic signed [5:0]  amt_i,
  // Shifted result.
  output logic             [39:0] y_o
);
  import dcs_pkg::*;
  logic [5:0] mag;
  logic [4:0] magc;

  // Counts beyond sixteen are clamped rather than wrapped.
  assign mag  = amt_i[5] ? 6'(-amt_i) : 6'(amt_i);
  assign magc = (mag > 6'(SH_MAX)) ? SH_MAX : mag[4:0];
  assign y_o  = amt_i[5] ? 40'($signed(x_i) >>> magc) : (x_i << magc);
endmodule : dcs_shift
`default_nettype wire

//--- rtl/dcs_core.sv
// Core datapath and status word of the signal controller, reached over APB.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE_01: A 23-bit program counter addresses program memory of 24-bit words.
// RULE_02: Instructions take one cycle; calls take two.
// RULE_03: Repeat and block loops cost nothing and an interrupt may pause them.
// RULE_04: Sixteen 16-bit working registers; the last is the stack pointer.
// RULE_05: Read, register read, memory write and fetch all fit one cycle.
// RULE_06: 32K-word data space with separate X and Y pointers.
// RULE_07: Modulo stepping on X and Y; bit-reversed stepping on X only.
// RULE_08: Upper data half may map to program memory via an 8-bit page.
// RULE_09: 17x17 multiplier, 40-bit ALU and two saturating 40-bit accumulators.
// RULE_10: 40-bit shifter moves up to 16 places either way in one cycle.
// RULE_11: Multiply-accumulate multiplies two registers and accumulates with optional saturation.
// RULE_12: Signed, unsigned and mixed multiply; minus one squared is exact.
// RULE_13: Divide runs 19 cycles in a repeat and survives interrupts.
// RULE_14: Status bits 15 and 14 show accumulator A and B overflow.
// RULE_15: Sticky bits 13 and 12 record saturation; software can only clear.
// RULE_16: Bit 11 is the OR of both overflow bits.
// RULE_17: Bit 10 ORs the sticky bits; clearing it clears both.
// RULE_18: Bit 9 is high while a block loop runs.
// RULE_19: Bit 8 is carry out of bit 3 for bytes, bit 7 for words.
// RULE_20: Priority level joins bits 7:5 with a control bit that blocks interrupts.
// RULE_21: Priority bits are read-only while nesting is disabled.
// RULE_22: Bit 4 is high while a repeat runs.
// RULE_23: Bit 3 shows a negative result.
// RULE_24: Bit 2 flags signed overflow; bit 0 is carry out of the top bit.
// RULE_25: Bit 1 is set by a zero result and cleared by non-zero.
// RULE_26: Reset clears the whole status word.
module dcs_core (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // APB slave.
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Core event and data-space view.
  input  wire logic                irq_i,
  input  wire logic [15:0]         dv_addr_i,
  output logic                     pv_hit_o,
  output logic      [22:0]         pv_addr_o,
  // Memory ports and priority.
  output logic      [22:0]         pm_addr_o,
  output dcs_pkg::dcs_dm_t         dm_o,
  output logic      [3:0]          priority_o,
  output logic                     user_irq_block_o
);
  import dcs_pkg::*;

  dcs_st_t     s;
  dcs_st_t     n;
  dcs_op_t     op;
  logic [3:0]  rd;
  logic [3:0]  rs;
  logic [3:0]  rt;
  logic [15:0] opa;
  logic [15:0] opb;
  logic [15:0] addb;
  logic        byte_op;
  logic        cin;
  logic [16:0] sum;
  logic [8:0]  lo9;
  logic [4:0]  lo5;
  logic [15:0] res;
  logic        msb_n;
  logic        acc_sel;
  logic        sat_en;
  logic [39:0] acc_cur;
  logic [39:0] sh_out;
  logic [40:0] addend;
  logic [40:0] raw;
  logic        clip;
  logic [39:0] acc_new;
  logic [33:0] prod;
  logic [16:0] dtry;
  logic        exec;
  logic        wr;
  logic        wr_stat;
  logic        mapped;
  logic        rep_on;
  logic [15:0] csw_v;
  logic        done;
  logic        w_hit;

  // Bit reversal for the X pointer's reversed-carry stepping.
  function automatic logic [15:0] brv(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : brv

  // Accumulator overflow: guard bits no longer a sign extension of bit 31.
  function automatic logic ovf(input logic [39:0] x);
    return !((&x[39:31]) | ~(|x[39:31]));
  endfunction : ovf

  // Command fields and the three-operand register reads.
  assign op      = dcs_op_t'(s.cmd[CM_OP +: 4]);
  assign rd      = s.cmd[CM_RD +: 4];
  assign rs      = s.cmd[CM_RS +: 4];
  assign rt      = s.cmd[CM_RT +: 4];
  assign byte_op = s.cmd[CM_BYTE];
  assign opa     = s.w[rs]; // RULE_05
  assign opb     = s.w[rt];

  // Integer adder; subtraction adds the complement so carry doubles as not-borrow.
  assign cin   = (op == OP_SUB);
  assign addb  = cin ? ~opb : opb;
  assign sum   = {1'b0, opa} + {1'b0, addb} + 17'(cin);
  assign lo9   = {1'b0, opa[7:0]} + {1'b0, addb[7:0]} + 9'(cin);
  assign lo5   = {1'b0, opa[3:0]} + {1'b0, addb[3:0]} + 5'(cin);
  assign res   = (op == OP_AND) ? (opa & opb) : sum[15:0];
  assign msb_n = byte_op ? res[7] : res[15];

  // Accumulator path shared by multiply-accumulate and shift.
  assign acc_sel = s.cmd[CM_ACC];
  assign acc_cur = acc_sel ? s.accb : s.acca;
  assign sat_en  = acc_sel ? s.ctrl[CT_SATB] : s.ctrl[CT_SATA];
  assign addend  = s.ctrl[CT_INT] ? 41'($signed(prod)) : 41'($signed({prod, 1'b0}));
  assign raw     = (op == OP_MAC) ? ({acc_cur[39], acc_cur} + addend) : {sh_out[39], sh_out}; // RULE_11
  // Clip to the 1.31 range; the true sign lives in the extra top bit.
  assign clip    = sat_en & ~((&raw[40:31]) | ~(|raw[40:31]));
  assign acc_new = clip ? (raw[40] ? SAT_NEG : SAT_POS) : raw[39:0]; // RULE_09

  // One multiplier serves both instruction classes; byte flag makes OP_MUL a mixed-sign multiply.
  dcs_mul u_mul (
    .a_i     (opa),
    .b_i     (opb),
    .a_uns_i (s.ctrl[CT_US]),
    .b_uns_i (s.ctrl[CT_US] | (op == OP_MUL && byte_op)),
    .p_o     (prod)
  ); // RULE_12

  dcs_shift u_shift (
    .x_i   (acc_cur),
    .amt_i (s.cmd[CM_SH +: 6]),
    .y_o   (sh_out)
  ); // RULE_10

  // Restoring divide trial subtraction on the partial remainder.
  assign dtry = {s.dr, s.dq[15]};

  // Bus decode; the interrupt freezes execution so loop and divide state wait intact.
  assign exec    = s.busy & ~irq_i; // RULE_03
  assign wr      = psel_i & penable_i & pwrite_i;
  assign wr_stat = wr && paddr_i == ADR_STAT;
  assign w_hit   = paddr_i[7:6] == ADR_WBASE[7:6];
  assign mapped  = (paddr_i[1:0] == 2'h0) && (paddr_i <= ADR_MODR || w_hit);

  // Composed status view: overflow and combined bits follow live state.
  assign rep_on = s.busy & ((s.rcnt != 8'h00) | (op == OP_DIV)); // RULE_22
  assign csw_v  = {ovf(s.acca), ovf(s.accb), s.csw[CW_ACLP], s.csw[CW_BCLP], // RULE_14
                   ovf(s.acca) | ovf(s.accb), s.csw[CW_ACLP] | s.csw[CW_BCLP], // RULE_16 RULE_17
                   s.dloop != 16'h0000, s.csw[CW_HCY], s.csw[CW_PRIO +: 3], rep_on, s.csw[3:0]}; // RULE_18

  // Next-state logic: bus effects first, then execution, so hardware sets win.
  always_comb begin
    n       = s;
    done    = 1'b0;
    n.dm.we = 1'b0;
    n.pvhit  = s.ctrl[CT_PSV] & dv_addr_i[15]; // RULE_08
    n.pvaddr = {s.pvpg, dv_addr_i[14:0]};
    if (psel_i && !penable_i) begin
      case (paddr_i)
        ADR_STAT: n.prdata = {16'h0000, csw_v};
        ADR_CTRL: n.prdata = {s.busy, 23'h00_0000, s.ctrl};
        ADR_PVPG: n.prdata = {24'h00_0000, s.pvpg};
        ADR_CMD:  n.prdata = s.cmd;
        ADR_PC:   n.prdata = {9'h000, s.pc};
        ADR_ACAL: n.prdata = s.acca[31:0];
        ADR_ACAH: n.prdata = {24'h00_0000, s.acca[39:32]};
        ADR_ACBL: n.prdata = s.accb[31:0];
        ADR_ACBH: n.prdata = {24'h00_0000, s.accb[39:32]};
        ADR_LOOP: n.prdata = {16'h0000, s.dloop};
        ADR_MODR: n.prdata = s.modr;
        default:  n.prdata = (w_hit && mapped) ? {16'h0000, s.w[paddr_i[5:2]]} : 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (paddr_i)
        ADR_STAT: begin
          n.csw[CW_ACLP] = s.csw[CW_ACLP] & pwdata_i[CW_ACLP] & pwdata_i[CW_ECLP]; // RULE_15 RULE_17
          n.csw[CW_BCLP] = s.csw[CW_BCLP] & pwdata_i[CW_BCLP] & pwdata_i[CW_ECLP];
          if (!s.ctrl[CT_NEST]) begin
            n.csw[CW_PRIO +: 3] = pwdata_i[CW_PRIO +: 3]; // RULE_21
          end
          n.csw[CW_HCY] = pwdata_i[CW_HCY];
          n.csw[3:0]    = pwdata_i[3:0];
        end
        ADR_CTRL: n.ctrl = pwdata_i[7:0];
        ADR_PVPG: n.pvpg = pwdata_i[7:0];
        ADR_CMD: begin
          if (!s.busy) begin
            n.cmd  = pwdata_i;
            n.busy = 1'b1;
            n.rcnt = pwdata_i[CM_REP +: 8];
          end
        end
        ADR_LOOP: n.dloop = pwdata_i[15:0];
        ADR_MODR: n.modr  = pwdata_i;
        default: begin
          if (w_hit && mapped) begin
            n.w[paddr_i[5:2]] = pwdata_i[15:0]; // RULE_04
          end
        end
      endcase
    end
    if (exec) begin
      case (op)
        OP_ADD, OP_SUB, OP_AND: begin
          if (byte_op) begin
            n.w[rd][7:0] = res[7:0];
            n.csw[CW_Z]  = res[7:0] == 8'h00;
          end else begin
            n.w[rd]      = res;
            n.csw[CW_Z]  = res == 16'h0000; // RULE_25
          end
          // AND keeps both carries, including a value software wrote in this cycle.
          if (op != OP_AND) begin
            n.csw[CW_C]   = byte_op ? lo9[8] : sum[16]; // RULE_24
            n.csw[CW_HCY] = byte_op ? lo5[4] : lo9[8]; // RULE_19
          end
          n.csw[CW_N] = msb_n; // RULE_23
          n.csw[CW_V] = (op != OP_AND) && ((byte_op ? (opa[7] == addb[7]) : (opa[15] == addb[15]))
                        && (msb_n != (byte_op ? opa[7] : opa[15]))); // RULE_24
          done = 1'b1;
        end
        OP_MUL: begin
          n.w[rd]             = prod[15:0];
          n.w[4'(rd + 4'h1)]  = prod[31:16];
          done = 1'b1;
        end
        OP_MAC, OP_SHA: begin
          // Building on the bus result lets a clip win over a clear in the same cycle.
          if (acc_sel) begin
            n.accb = acc_new;
            n.csw[CW_BCLP] = n.csw[CW_BCLP] | clip;
          end else begin
            n.acca = acc_new;
            n.csw[CW_ACLP] = n.csw[CW_ACLP] | clip; // RULE_15
          end
          done = 1'b1;
        end
        OP_DIV: begin
          if (s.dv_cnt == 5'h00) begin
            n.dv_cnt = DIV_LOAD;
            n.dr     = byte_op ? 16'h0000 : s.w[4'(rs + 4'h1)];
            n.dq     = opa;
          end else begin
            n.dv_cnt = s.dv_cnt - 5'h01;
            if (s.dv_cnt >= DIV_ITLO && s.dv_cnt < DIV_LOAD) begin
              n.dr = (dtry >= {1'b0, opb}) ? 16'(dtry - {1'b0, opb}) : dtry[15:0];
              n.dq = {s.dq[14:0], dtry >= {1'b0, opb}};
            end
            if (s.dv_cnt == 5'h01) begin
              n.w[0] = s.dq; // RULE_13
              n.w[1] = s.dr;
              done   = 1'b1;
            end
          end
        end
        OP_AGU: begin
          // X steps reversed or modulo; Y only modulo.
          if (s.ctrl[CT_BREV]) begin
            n.w[W_XP] = brv(brv(s.w[W_XP]) + brv(opb)); // RULE_07
          end else begin
            n.w[W_XP] = (s.w[W_XP] == s.modr[31:16]) ? s.modr[15:0] : s.w[W_XP] + ADDR_STEP; // RULE_06
          end
          n.w[W_YP] = (s.w[W_YP] == s.modr[31:16]) ? s.modr[15:0] : s.w[W_YP] + ADDR_STEP;
          done = 1'b1;
        end
        OP_CALL: begin
          // First cycle pushes the return address, second changes flow.
          if (!s.call2) begin
            n.dm.we   = 1'b1;
            n.dm.addr = s.w[W_SP];
            n.dm.data = 16'(s.pc + PC_STEP);
            n.w[W_SP] = s.w[W_SP] + ADDR_STEP; // RULE_04
            n.call2   = 1'b1;
          end else begin
            n.call2 = 1'b0;
            n.pc    = {7'h00, opa}; // RULE_02
            done    = 1'b1;
          end
        end
        default: done = 1'b1;
      endcase
      if (done) begin
        if (s.rcnt != 8'h00) begin
          n.rcnt = s.rcnt - 8'h01; // RULE_03
        end else begin
          n.busy = 1'b0;
          if (op != OP_CALL) begin
            n.pc = s.pc + PC_STEP; // RULE_01
          end
          if (s.dloop != 16'h0000) begin
            n.dloop = s.dloop - 16'h0001;
          end
        end
      end
    end
  end

  // Single state register; reset clears all flags and controls.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= ST_RST; // RULE_26
    end else begin
      s <= n;
    end
  end

  // Zero-wait slave; read data was captured in the setup cycle.
  assign prdata_o         = s.prdata;
  assign pready_o         = 1'b1;
  assign pslverr_o        = psel_i & penable_i & (~mapped | (pwrite_i & paddr_i == ADR_CMD & s.busy));
  assign pv_hit_o         = s.pvhit;
  assign pv_addr_o        = s.pvaddr;
  assign pm_addr_o        = s.pc;
  assign dm_o             = s.dm;
  assign priority_o       = {s.ctrl[CT_PRI3], s.csw[CW_PRIO +: 3]}; // RULE_20
  assign user_irq_block_o = s.ctrl[CT_PRI3];

  // Counts divide cycles for the length check.
  logic [4:0] dcyc_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dcyc_q <= 5'h00;
    end else if (exec && op == OP_DIV) begin
      dcyc_q <= (s.dv_cnt == 5'h01) ? 5'h00 : dcyc_q + 5'h01;
    end
  end

  default clocking dcs_cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_div_length: assert property (exec && op == OP_DIV && s.dv_cnt == 5'h01 |-> dcyc_q == DIV_LOAD) // RULE_13
    else $error("divide did not take nineteen cycles");
  a_sticky_hold: assert property (s.csw[CW_ACLP] && !wr_stat |=> csw_v[CW_ACLP] && csw_v[CW_ECLP]) // RULE_15
    else $error("sticky saturation bit lost");
  a_either_clear: assert property (wr_stat && !pwdata_i[CW_ECLP] && !(exec && (op == OP_MAC || op == OP_SHA)) // RULE_17
    |=> !csw_v[CW_ACLP] && !csw_v[CW_BCLP])
    else $error("combined clear left a sticky bit");
  a_prio_locked: assert property (wr_stat && s.ctrl[CT_NEST] |=> $stable(priority_o[2:0])) // RULE_21
    else $error("priority changed while locked");
  a_pc_advance: assert property (exec && op == OP_ADD && s.rcnt == 8'h00 // RULE_01
    |=> pm_addr_o == $past(pm_addr_o) + PC_STEP)
    else $error("program counter did not advance");
  a_repeat_flag: assert property (wr && paddr_i == ADR_CMD && !s.busy && pwdata_i[CM_REP +: 8] != 8'h00 // RULE_22
    |=> csw_v[CW_REP] ##1 (csw_v[CW_REP] || !irq_i))
    else $error("repeat flag missing");
  a_loop_flag: assert property (wr && paddr_i == ADR_LOOP && pwdata_i[15:0] != 16'h0000 && !exec // RULE_18
    |=> csw_v[CW_LOOP])
    else $error("block loop flag missing");
  a_view_map: assert property (s.ctrl[CT_PSV] && dv_addr_i[15] // RULE_08
    |=> pv_hit_o && pv_addr_o == {$past(s.pvpg), $past(dv_addr_i[14:0])})
    else $error("program view mapping wrong");
  a_zero_flag: assert property (exec && (op == OP_ADD || op == OP_SUB) && !byte_op && res == 16'h0000 // RULE_25
    |=> csw_v[CW_Z])
    else $error("zero flag not set");
  a_frac_exact: assert property (opa == 16'h8000 && opb == 16'h8000 && !s.ctrl[CT_US] && op != OP_MUL // RULE_12
    |-> prod == 34'h0_4000_0000)
    else $error("minus one squared inexact");
  a_mac_clip: assert property (exec && op == OP_MAC && !acc_sel && clip // RULE_15
    |=> (s.acca == SAT_POS || s.acca == SAT_NEG) && csw_v[CW_ACLP])
    else $error("accumulator A not clipped");

  c_div_done: cover property (exec && op == OP_DIV && s.dv_cnt == 5'h01);
  c_mac_clip: cover property (exec && op == OP_MAC && clip);
  c_call: cover property (exec && op == OP_CALL && s.call2);
  c_irq_pause: cover property (s.busy && irq_i && s.rcnt != 8'h00);
endmodule : dcs_core
`default_nettype wire

//--- testbench/dcs_far_mem.sv
// Far-side data memory and interrupt source used by the core bench.
`timescale 1ns/1ns
`default_nettype none
module dcs_far_mem (
  // Clock and core write port.
  input  wire logic             clk_i,
  input  wire dcs_pkg::dcs_dm_t dm_i,
  // Interrupt burst trigger and request.
  input  wire logic             go_i,
  output logic                  irq_o
);
  import dcs_pkg::*;
  logic [15:0] mem [0:255];
  logic [1:0]  left_q = 2'h0;
  // Word writes land on the next edge, as in a synchronous RAM.
  always_ff @(posedge clk_i) begin
    if (dm_i.we) begin
      mem[dm_i.addr[8:1]] <= dm_i.data;
    end
  end
  // The request stands three cycles, so a running divide must freeze and then resume.
  always_ff @(posedge clk_i) begin
    left_q <= go_i ? 2'h3 : left_q - 2'(left_q != 2'h0);
  end
  assign irq_o = (left_q != 2'h0);
endmodule : dcs_far_mem
`default_nettype wire

//--- testbench/dsp_core_status_datapath_bench.sv
// Self-checking bench for the core datapath and its status word.
`timescale 1ns/1ns
`default_nettype none
module dsp_core_status_datapath_bench;
  import dcs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] dv = 16'h0000;
  logic [31:0] prdata;
  logic        pready, pslverr, pv_hit, ublk, irq;
  logic [22:0] pv_addr, pm_addr;
  logic [3:0]  prio;
  dcs_dm_t     dm;
  int          n_mismatch = 0;
  int          check_count = 0;
  logic [64:0] noteq[$];
  logic [64:0] note;
  logic [15:0] a, b, pcx;
  logic [16:0] sum;
  logic [8:0]  s9;
  logic [31:0] dvd;
  dcs_core u_dcs_core (.clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_i(irq), .dv_addr_i(dv), .pv_hit_o(pv_hit), .pv_addr_o(pv_addr), .pm_addr_o(pm_addr),
    .dm_o(dm), .priority_o(prio), .user_irq_block_o(ublk));
  dcs_far_mem u_dcs_far_mem (.clk_i(clk), .dm_i(dm), .go_i(go), .irq_o(irq));
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // The request is held until pready is seen, then released with one idle cycle after it.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m, input logic er);
    noteq.push_back({er, m, e & m});
    apb(1'b0, ad, 32'h0000_0000);
  endtask : rd
  task automatic op(input logic [31:0] c);
    apb(1'b1, ADR_CMD, c);
    repeat (2) @(posedge clk);
    pcx += 16'h0002;
  endtask : op
  // Read data and error are compared at the edge that completes each read access.
  always @(posedge clk) begin
    if (psel && pen && pready && !pwr && noteq.size() > 0) begin
      note = noteq.pop_front();
      check(prdata & note[63:32], note[31:0]);
      check({31'h0, pslverr}, {31'h0, note[64]});
    end
  end
  // Hang guard, far beyond the length of the sequence below.
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    void'($urandom(32'h7950_b508));
    pcx = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADR_STAT, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(8'h2C, 32'h0, 32'hFFFF_FFFF, 1'b1);
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 16'h7FFF : 16'($urandom);
      b = (i == 0) ? 16'h0001 : 16'($urandom);
      sum = {1'b0, a} + {1'b0, b};
      s9 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
      apb(1'b1, ADR_WBASE + 8'h04, {16'h0, a});
      apb(1'b1, ADR_WBASE + 8'h08, {16'h0, b});
      op(32'h0000_2131);
      rd(ADR_WBASE + 8'h0C, {15'h0, sum}, 32'h0000_FFFF, 1'b0);
      rd(ADR_STAT, {16'h0, 7'h0, s9[8], 4'h0, sum[15], (a[15] == b[15]) && (sum[15] != a[15]),
        sum[15:0] == 16'h0, sum[16]}, 32'hFFFF_FFFF, 1'b0);
      rd(ADR_PC, {16'h0, pcx}, 32'h007F_FFFF, 1'b0);
    end
    op(32'h0000_1132);
    rd(ADR_STAT, 32'h0000_0103, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, ADR_STAT, 32'h0000_FFFF);
    rd(ADR_STAT, 32'h0000_01EF, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, ADR_CTRL, 32'h0000_0081);
    apb(1'b1, ADR_STAT, 32'h0000_0000);
    rd(ADR_STAT, 32'h0000_00E0, 32'hFFFF_FFFF, 1'b0);
    check({27'h0, ublk, prio}, 32'h0000_001F);
    apb(1'b1, ADR_CTRL, 32'h0000_0000);
    apb(1'b1, ADR_STAT, 32'h0000_0000);
    apb(1'b1, ADR_WBASE + 8'h04, 32'h0000_8000);
    apb(1'b1, ADR_WBASE + 8'h08, 32'h0000_8000);
    op(32'h0000_2105);
    rd(ADR_ACAL, 32'h8000_0000, 32'hFFFF_FFFF, 1'b0);
    rd(ADR_STAT, 32'h0000_8800, 32'h0000_FC00, 1'b0);
    apb(1'b1, ADR_CTRL, 32'h0000_0004);
    op(32'h0000_2105);
    rd(ADR_ACAL, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 1'b0);
    rd(ADR_STAT, 32'h0000_2400, 32'h0000_FC00, 1'b0);
    apb(1'b1, ADR_STAT, 32'h0000_2000);
    rd(ADR_STAT, 32'h0000_0000, 32'h0000_FC00, 1'b0);
    b = 16'($urandom) | 16'h0001;
    dvd = {16'($urandom) % b, 16'($urandom)};
    apb(1'b1, ADR_WBASE + 8'h10, {16'h0, dvd[15:0]});
    apb(1'b1, ADR_WBASE + 8'h14, {16'h0, dvd[31:16]});
    apb(1'b1, ADR_WBASE + 8'h18, {16'h0, b});
    apb(1'b1, ADR_CMD, 32'h0000_6407);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    rd(ADR_CTRL, 32'h8000_0000, 32'h8000_0000, 1'b0);
    rd(ADR_STAT, 32'h0000_0010, 32'h0000_0010, 1'b0);
    repeat (20) @(posedge clk);
    pcx += 16'h0002;
    rd(ADR_CTRL, 32'h0, 32'h8000_0000, 1'b0);
    rd(ADR_WBASE, dvd / b, 32'h0000_FFFF, 1'b0);
    rd(ADR_WBASE + 8'h04, dvd % b, 32'h0000_FFFF, 1'b0);
    apb(1'b1, ADR_WBASE + 8'h3C, 32'h0000_0100);
    apb(1'b1, ADR_WBASE + 8'h1C, 32'h0000_0040);
    apb(1'b1, ADR_CMD, 32'h0000_0709);
    repeat (3) @(posedge clk);
    check({16'h0, u_dcs_far_mem.mem[8'h80]}, {16'h0, pcx + 16'h0002});
    check({9'h0, pm_addr}, 32'h0000_0040);
    rd(ADR_WBASE + 8'h3C, 32'h0000_0102, 32'h0000_FFFF, 1'b0);
    apb(1'b1, ADR_CTRL, 32'h0000_0002);
    apb(1'b1, ADR_PVPG, 32'h0000_005A);
    dv <= {1'b1, 15'($urandom)};
    repeat (2) @(posedge clk);
    check({31'h0, pv_hit}, 32'h1);
    check({9'h0, pv_addr}, {9'h0, 8'h5A, dv[14:0]});
    // Arithmetic right shift of the clipped accumulator by sixteen places.
    op(32'h00C0_0006);
    rd(ADR_ACAL, 32'h0000_7FFF, 32'hFFFF_FFFF, 1'b0);
    // Mixed-sign multiply: signed minus one times unsigned 65535.
    apb(1'b1, ADR_WBASE + 8'h04, 32'h0000_FFFF);
    apb(1'b1, ADR_WBASE + 8'h08, 32'h0000_FFFF);
    op(32'h0001_2144);
    rd(ADR_WBASE + 8'h10, 32'h0000_0001, 32'h0000_FFFF, 1'b0);
    rd(ADR_WBASE + 8'h14, 32'h0000_FFFF, 32'h0000_FFFF, 1'b0);
    // Four modulo steps under a repeat, inside a one-pass block loop.
    apb(1'b1, ADR_MODR, 32'h0104_0100);
    apb(1'b1, ADR_LOOP, 32'h0000_0001);
    apb(1'b1, ADR_WBASE + 8'h20, 32'h0000_0100);
    apb(1'b1, ADR_WBASE + 8'h28, 32'h0000_0100);
    apb(1'b1, ADR_CMD, 32'h0300_0008);
    rd(ADR_STAT, 32'h0000_0210, 32'h0000_0210, 1'b0);
    repeat (4) @(posedge clk);
    rd(ADR_STAT, 32'h0000_0000, 32'h0000_0210, 1'b0);
    rd(ADR_WBASE + 8'h20, 32'h0000_0102, 32'h0000_FFFF, 1'b0);
    rd(ADR_WBASE + 8'h28, 32'h0000_0102, 32'h0000_FFFF, 1'b0);
    final_report();
  end
endmodule : dsp_core_status_datapath_bench
`default_nettype wire
